/* File: hw/pic_top.sv */
// Contract
// - One request per group until end-of-service
// - Both external lines together: first wins
// - External-controller interrupt ignores group nesting
// - External-controller accept disables interrupts
// - Whole group shares one register bank
// - No bank switch for time base; others by enable bit
// - Bank switch saves only PC and PSW
// - Bank from group's top source field
// - End-of-service clears lowest in-service bit
// - No acceptance right after end-of-service, except break
// - Software-set flag acts as hardware request
// - One macro transfer per request
// - Bus driven only for external memory
// - Count zero turns source back to interrupt
// - Enable bit picks vector or bank
// - Acknowledge cycle never takes wait states
// - Accept only at instruction boundaries
// - Accepted source readable afterwards
// - Bank writes land at data base window
module pic_top #(
    parameter int G = pic_pkg::NUM_GRP,
    parameter int S = pic_pkg::SRC_PER_GRP
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Request sources
    input  wire logic [G*S-1:0]               hw_req_i,
    input  wire logic                         sw_set_i,
    input  wire logic [$clog2(G*S)-1:0]       sw_idx_i,
    input  wire logic                         ext_request_line_a_i,
    input  wire logic                         ext_request_line_b_i,
    input  wire logic                         ext_ctrl_req_i,
    input  wire logic [pic_pkg::VEC_W-1:0]    ext_vec_i,
    // Source configuration
    input  wire logic                         cfg_wr_i,
    input  wire logic [$clog2(G*S)-1:0]       cfg_idx_i,
    input  wire logic                         cfg_mask_i,
    input  wire logic                         cfg_ms_i,
    input  wire logic                         cfg_bank_switch_enable_i,
    input  wire logic [pic_pkg::BANK_W-1:0]   cfg_bank_i,
    input  wire logic                         cfg_sfr_i,
    input  wire logic [pic_pkg::CNT_W-1:0]    cfg_cnt_i,
    // Processor status
    input  wire logic                         instr_boundary_i,
    input  wire logic                         irq_enabled_i,
    input  wire logic                         eos_instr_i,
    input  wire logic                         brk_bank_i,
    input  wire logic [pic_pkg::BANK_W-1:0]   brk_bank_num_i,
    // Data memory writes
    input  wire logic                         mem_wr_i,
    input  wire logic [pic_pkg::ADDR_W-1:0]   mem_addr_i,
    input  wire logic [pic_pkg::DATA_W-1:0]   mem_data_i,
    input  wire logic [pic_pkg::IDB_W-1:0]    internal_data_base_i,
    // Response
    output logic                              accept_o,
    output pic_pkg::pic_resp_type             resp_kind_o,
    output logic [$clog2(G*S)-1:0]            irq_source_o,
    output logic [pic_pkg::BANK_W-1:0]        bank_o,
    output logic                              save_pc_psw_o,
    output logic                              disable_irq_o,
    output logic [G-1:0]                      in_service_o,
    output logic [G*S-1:0]                    pending_o,
    output logic [G*S-1:0]                    ms_sel_o,
    // External controller acknowledge
    output logic                              irq_ack_cycle_o,
    output logic [pic_pkg::VEC_W-1:0]         ext_vec_o,
    output logic                              ext_vec_valid_o,
    // Macro service
    output logic                              macro_xfer_o,
    output logic                              macro_ext_bus_o,
    // Register bank writes
    output logic                              bank_wr_o,
    output logic [pic_pkg::OFS_W-1:0]         bank_wr_addr_o,
    output logic [pic_pkg::DATA_W-1:0]        bank_wr_data_o
);

    localparam int N   = G * S;
    localparam int SW  = $clog2(N);
    localparam int GW  = $clog2(G);
    localparam int PW  = $clog2(S);

    if (G != pic_pkg::NUM_GRP || pic_pkg::EXT_B_SRC >= N || S < 2) begin : g_bad_cfg
        $error("pic_top: geometry does not match fixed source positions");
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [G-1:0] upto_mask(input logic [GW-1:0] g);
        logic [G-1:0] m;
        m = '0;
        for (int i = 0; i < G; i++) begin
            m[i] = (GW'(i) <= g);
        end
        return m;
    endfunction

    function automatic logic [SW-1:0] grp_top(input logic [GW-1:0] g);
        return SW'(g * S);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0]                pin_s1_q, pin_s2_q, pin_s3_q;
    logic [pic_pkg::VEC_W-1:0] vec_s1_q, vec_s2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
            vec_s1_q <= '0;
            vec_s2_q <= '0;
        end else begin
            pin_s1_q <= {ext_ctrl_req_i, ext_request_line_b_i, ext_request_line_a_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            vec_s1_q <= ext_vec_i;
            vec_s2_q <= vec_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic [N-1:0]            flag_q, flag_d, mask_q, mask_d, ms_q, ms_d;
    logic [N-1:0]            bank_switch_enable_q, bank_switch_enable_d, sfr_q, sfr_d, elig;
    logic [pic_pkg::BANK_W-1:0] bank_q [N];
    logic [pic_pkg::BANK_W-1:0] bank_d [N];
    logic [pic_pkg::CNT_W-1:0]  cnt_q [N];
    logic [pic_pkg::CNT_W-1:0]  cnt_d [N];
    logic [G-1:0]            in_service_priority_reg_q, in_service_priority_reg_d, grp_hit, grp_ok;
    logic [PW-1:0]           grp_pos [G];
    logic                    win_found;
    logic [GW-1:0]           win_grp;
    logic [SW-1:0]           win_src;

    assign elig = flag_q & ~mask_q;

    for (genvar g = 0; g < G; g++) begin : g_grp
        pic_prio_enc #(.W(S), .IW(PW)) u_src_enc (
            .req_i   (elig[g*S +: S]),
            .found_o (grp_hit[g]),
            .idx_o   (grp_pos[g])
        );
    end

    // A group is held while its own or a higher level is in service
    always_comb begin
        for (int g = 0; g < G; g++) begin
            grp_ok[g] = grp_hit[g] & ~(|(in_service_priority_reg_q & upto_mask(GW'(g))));
        end
    end

    pic_prio_enc #(.W(G), .IW(GW)) u_grp_enc (
        .req_i   (grp_ok),
        .found_o (win_found),
        .idx_o   (win_grp)
    );

    assign win_src = grp_top(win_grp) + SW'(grp_pos[win_grp]);

    // ------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------
    logic                    inhibit_q, inhibit_d, take;
    logic                    acc_d, save_d, dis_d, mx_d, mbus_d;
    logic                    accept_q, save_q, dis_q, mx_q, mbus_q;
    pic_pkg::pic_resp_type   resp_q, resp_d;
    logic [SW-1:0]           src_q, src_d;
    logic [GW-1:0]           agrp_q, agrp_d;
    logic [pic_pkg::BANK_W-1:0] bnk_q, bnk_d;
    pic_pkg::pic_ack_type    ack_st_q, ack_st_d;
    logic                    ack_q, vval_q;
    logic [pic_pkg::VEC_W-1:0] vec_q;

    // The boundary that ends end-of-service itself and the next one stay closed
    assign take = instr_boundary_i & ~inhibit_q & ~eos_instr_i;

    always_comb begin
        flag_d    = flag_q;
        mask_d    = mask_q;
        ms_d      = ms_q;
        bank_switch_enable_d    = bank_switch_enable_q;
        sfr_d     = sfr_q;
        bank_d    = bank_q;
        cnt_d     = cnt_q;
        in_service_priority_reg_d    = in_service_priority_reg_q;
        inhibit_d = inhibit_q;
        acc_d     = 1'b0;
        save_d    = 1'b0;
        dis_d     = 1'b0;
        mx_d      = 1'b0;
        mbus_d    = 1'b0;
        resp_d    = pic_pkg::RESP_NONE;
        src_d     = src_q;
        agrp_d    = agrp_q;
        bnk_d     = bnk_q;
        ack_st_d  = ack_st_q;

        if (eos_instr_i) begin
            in_service_priority_reg_d    = in_service_priority_reg_q & (in_service_priority_reg_q - G'(1));
            inhibit_d = 1'b1;
        end else if (instr_boundary_i) begin
            inhibit_d = 1'b0;
        end

        if (cfg_wr_i) begin
            mask_d[cfg_idx_i] = cfg_mask_i;
            ms_d[cfg_idx_i]   = cfg_ms_i;
            bank_switch_enable_d[cfg_idx_i] = cfg_bank_switch_enable_i;
            sfr_d[cfg_idx_i]  = cfg_sfr_i;
            bank_d[cfg_idx_i] = cfg_bank_i;
            cnt_d[cfg_idx_i]  = cfg_cnt_i;
        end

        unique case (ack_st_q)
            pic_pkg::ACK_IDLE:  ack_st_d = pic_pkg::ACK_IDLE;
            pic_pkg::ACK_DRIVE: ack_st_d = pic_pkg::ACK_SYNC;
            pic_pkg::ACK_SYNC:  ack_st_d = pic_pkg::ACK_TAKE;
            pic_pkg::ACK_TAKE:  ack_st_d = pic_pkg::ACK_IDLE;
        endcase

        if (instr_boundary_i && brk_bank_i) begin
            acc_d  = 1'b1;
            resp_d = pic_pkg::RESP_BRK;
            bnk_d  = brk_bank_num_i;
            save_d = 1'b1;
        end else if (take && irq_enabled_i && pin_s2_q[2] && ack_st_q == pic_pkg::ACK_IDLE) begin
            acc_d    = 1'b1;
            resp_d   = pic_pkg::RESP_EXT;
            dis_d    = 1'b1;
            ack_st_d = pic_pkg::ACK_DRIVE;
        end else if (take && irq_enabled_i && win_found) begin
            acc_d          = 1'b1;
            src_d          = win_src;
            agrp_d         = win_grp;
            flag_d[win_src] = 1'b0;
            if (ms_q[win_src]) begin
                resp_d = pic_pkg::RESP_MACRO;
                mx_d   = 1'b1;
                mbus_d = ~sfr_q[win_src];
                cnt_d[win_src] = cnt_q[win_src] - pic_pkg::CNT_ONE;
                if (cnt_q[win_src] <= pic_pkg::CNT_ONE) begin
                    cnt_d[win_src] = pic_pkg::CNT_RST;
                    ms_d[win_src]  = 1'b0;
                end
            end else begin
                dis_d          = 1'b1;
                in_service_priority_reg_d[win_grp] = 1'b1;
                if (bank_switch_enable_q[win_src] && win_src != SW'(pic_pkg::TB_SRC)) begin
                    resp_d = pic_pkg::RESP_BANK;
                    bnk_d  = bank_q[grp_top(win_grp)];
                    save_d = 1'b1;
                end else begin
                    resp_d = pic_pkg::RESP_VECTOR;
                end
            end
        end

        // Fresh requests override the clear of the same cycle
        flag_d = flag_d | hw_req_i;
        if (sw_set_i) begin
            flag_d[sw_idx_i] = 1'b1;
        end
        if (pin_s2_q[0] && !pin_s3_q[0]) begin
            flag_d[pic_pkg::EXT_A_SRC] = 1'b1;
        end
        if (pin_s2_q[1] && !pin_s3_q[1]) begin
            flag_d[pic_pkg::EXT_B_SRC] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q    <= '0;
            mask_q    <= '1;
            ms_q      <= '0;
            bank_switch_enable_q    <= '0;
            sfr_q     <= '0;
            for (int i = 0; i < N; i++) begin
                bank_q[i] <= '0;
                cnt_q[i]  <= pic_pkg::CNT_RST;
            end
            in_service_priority_reg_q    <= pic_pkg::IN_SERVICE_PRIORITY_REG_RST;
            inhibit_q <= 1'b0;
            accept_q  <= 1'b0;
            save_q    <= 1'b0;
            dis_q     <= 1'b0;
            mx_q      <= 1'b0;
            mbus_q    <= 1'b0;
            resp_q    <= pic_pkg::RESP_NONE;
            src_q     <= '0;
            agrp_q    <= '0;
            bnk_q     <= '0;
            ack_st_q  <= pic_pkg::ACK_IDLE;
            ack_q     <= 1'b0;
            vval_q    <= 1'b0;
            vec_q     <= '0;
        end else begin
            flag_q    <= flag_d;
            mask_q    <= mask_d;
            ms_q      <= ms_d;
            bank_switch_enable_q    <= bank_switch_enable_d;
            sfr_q     <= sfr_d;
            bank_q    <= bank_d;
            cnt_q     <= cnt_d;
            in_service_priority_reg_q    <= in_service_priority_reg_d;
            inhibit_q <= inhibit_d;
            accept_q  <= acc_d;
            save_q    <= save_d;
            dis_q     <= dis_d;
            mx_q      <= mx_d;
            mbus_q    <= mbus_d;
            resp_q    <= resp_d;
            src_q     <= src_d;
            agrp_q    <= agrp_d;
            bnk_q     <= bnk_d;
            ack_st_q  <= ack_st_d;
            ack_q     <= (ack_st_d == pic_pkg::ACK_DRIVE);
            vval_q    <= (ack_st_q == pic_pkg::ACK_TAKE);
            vec_q     <= (ack_st_q == pic_pkg::ACK_TAKE) ? vec_s2_q : vec_q;
        end
    end

    // ------------------------------------------------------------
    // Register bank window
    // ------------------------------------------------------------
    logic                        bwr_q, bwr_d;
    logic [pic_pkg::OFS_W-1:0]   bofs_q, bofs_d;
    logic [pic_pkg::DATA_W-1:0]  bdat_q, bdat_d;

    always_comb begin
        bwr_d  = mem_wr_i
               && mem_addr_i[pic_pkg::ADDR_W-1 -: pic_pkg::IDB_W] == internal_data_base_i
               && mem_addr_i[pic_pkg::PAGE_LSB +: pic_pkg::PAGE_W] == pic_pkg::BANK_PAGE;
        bofs_d = bwr_d ? mem_addr_i[pic_pkg::OFS_W-1:0] : bofs_q;
        bdat_d = bwr_d ? mem_data_i : bdat_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bwr_q  <= 1'b0;
            bofs_q <= '0;
            bdat_q <= '0;
        end else begin
            bwr_q  <= bwr_d;
            bofs_q <= bofs_d;
            bdat_q <= bdat_d;
        end
    end

    assign accept_o        = accept_q;
    assign resp_kind_o     = resp_q;
    assign irq_source_o    = src_q;
    assign bank_o          = bnk_q;
    assign save_pc_psw_o   = save_q;
    assign disable_irq_o   = dis_q;
    assign in_service_o    = in_service_priority_reg_q;
    assign pending_o       = flag_q;
    assign ms_sel_o        = ms_q;
    assign irq_ack_cycle_o = ack_q;
    assign ext_vec_o       = vec_q;
    assign ext_vec_valid_o = vval_q;
    assign macro_xfer_o    = mx_q;
    assign macro_ext_bus_o = mbus_q;
    assign bank_wr_o       = bwr_q;
    assign bank_wr_addr_o  = bofs_q;
    assign bank_wr_data_o  = bdat_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence ext_accept_s;
        accept_o && resp_kind_o == pic_pkg::RESP_EXT;
    endsequence
    sequence ack_pulse_s;
        irq_ack_cycle_o ##1 !irq_ack_cycle_o[*3];
    endsequence
    logic prio_acc;
    assign prio_acc = accept_o && (resp_kind_o == pic_pkg::RESP_VECTOR
                                   || resp_kind_o == pic_pkg::RESP_BANK);

    ack_no_wait_a: assert property (ext_accept_s |-> disable_irq_o and ack_pulse_s)
        else $error("acknowledge cycle not a single cycle");
    ext_vec_take_a: assert property (ext_accept_s |-> ##3 ext_vec_valid_o)
        else $error("external vector not taken three cycles after accept");
    boundary_only_a: assert property (accept_o && resp_kind_o != pic_pkg::RESP_BRK
                                      |-> $past(instr_boundary_i) && !$past(inhibit_q))
        else $error("accept off an instruction boundary");
    eos_quiet_a: assert property (eos_instr_i ##1 !instr_boundary_i[*1] ##1 instr_boundary_i
                                  |=> !accept_o || resp_kind_o == pic_pkg::RESP_BRK)
        else $error("accept directly after end of service");
    eos_clear_a: assert property (eos_instr_i && !acc_d
                                  |=> in_service_o == ($past(in_service_priority_reg_q) & ($past(in_service_priority_reg_q) - G'(1))))
        else $error("end of service cleared wrong bit");
    group_hold_a: assert property (prio_acc |-> ($past(in_service_priority_reg_q) & upto_mask(agrp_q)) == '0)
        else $error("group accepted while its level in service");
    in_service_priority_reg_set_a: assert property (prio_acc |-> in_service_o[agrp_q] && disable_irq_o)
        else $error("in-service bit not set on accept");
    bank_field_a: assert property (accept_o && resp_kind_o == pic_pkg::RESP_BANK
                                   |-> bank_o == bank_q[grp_top(agrp_q)]
                                       && irq_source_o != SW'(pic_pkg::TB_SRC)
                                       && save_pc_psw_o)
        else $error("bank response with wrong bank or source");
    macro_once_a: assert property (macro_xfer_o |-> accept_o && !pending_o[irq_source_o]
                                   ##1 (!macro_xfer_o
                                        || irq_source_o != $past(irq_source_o)))
        else $error("macro service not a single transfer");
    macro_end_a: assert property (macro_xfer_o && $past(cnt_q[src_d]) <= pic_pkg::CNT_ONE
                                  |-> !ms_sel_o[irq_source_o])
        else $error("select bit kept after count reached zero");

endmodule // pic_top

/* File: hw/pic_pkg.sv */
package pic_pkg;

    // ------------------------------------------------------------
    // Arbitration geometry
    // ------------------------------------------------------------
    localparam int NUM_GRP     = 8;
    localparam int SRC_PER_GRP = 3;
    localparam int BANK_W      = 3;
    localparam int CNT_W       = 8;

    // Fixed source positions (source index = group * SRC_PER_GRP + position)
    localparam int EXT_A_SRC   = 3;
    localparam int EXT_B_SRC   = 4;
    localparam int TB_SRC      = 0;

    // ------------------------------------------------------------
    // Register bank window in data memory
    // ------------------------------------------------------------
    localparam int          ADDR_W    = 20;
    localparam int          IDB_W     = 8;
    localparam int          PAGE_LSB  = 8;
    localparam int          PAGE_W    = 4;
    localparam logic [3:0]  BANK_PAGE = 4'he;
    localparam int          OFS_W     = 8;
    localparam int          DATA_W    = 16;
    localparam int          VEC_W     = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NUM_GRP-1:0] IN_SERVICE_PRIORITY_REG_RST = 8'h00;
    localparam logic [CNT_W-1:0]   CNT_RST  = 8'h00;
    localparam logic [CNT_W-1:0]   CNT_ONE  = 8'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RESP_NONE   = 3'h0,
        RESP_VECTOR = 3'h1,
        RESP_BANK   = 3'h2,
        RESP_MACRO  = 3'h3,
        RESP_EXT    = 3'h4,
        RESP_BRK    = 3'h5
    } pic_resp_type;

    typedef enum logic [1:0] {
        ACK_IDLE  = 2'h0,
        ACK_DRIVE = 2'h1,
        ACK_SYNC  = 2'h3,
        ACK_TAKE  = 2'h2
    } pic_ack_type;

endpackage

/* File: hw/pic_prio_enc.sv */
// Lowest set bit wins; the lower index is the higher priority
module pic_prio_enc #(
    parameter int W  = 3,
    parameter int IW = 2
) (
    input  wire logic [W-1:0]  req_i,
    output logic               found_o,
    output logic [IW-1:0]      idx_o
);

    if (W > (1 << IW)) begin : g_bad_width
        $error("pic_prio_enc: index too narrow");
    end

    always_comb begin
        found_o = 1'b0;
        idx_o   = '0;
        for (int i = W - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                found_o = 1'b1;
                idx_o   = IW'(i);
            end
        end
    end

endmodule // pic_prio_enc

/* File: tb/pic_ext_ctrl_model.sv */
// External interrupt controller on the acknowledge side of the block
module pic_ext_ctrl_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench control
    input  wire logic       go_i,
    input  wire logic [7:0] vec_i,
    // Acknowledge side
    input  wire logic       irq_ack_cycle_i,
    output logic            ext_ctrl_req_o,
    output logic [7:0]      ext_vec_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] hold_q;

    // Vector stays up from the request until well past the ack, then is released
    // to its inverse so a stale value can never pass for a fresh one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_ctrl_req_o <= 1'b0;
            ext_vec_o      <= 8'h00;
            hold_q         <= 3'h0;
        end else begin
            if (go_i) begin
                ext_ctrl_req_o <= 1'b1;
                ext_vec_o      <= vec_i;
            end
            if (irq_ack_cycle_i) begin
                ext_ctrl_req_o <= 1'b0;
                hold_q         <= 3'h4;
            end else if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
                if (hold_q == 3'h1) ext_vec_o <= ~ext_vec_o;
            end
        end
    end
endmodule // pic_ext_ctrl_model

/* File: tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic clk, rst = 1, sw_set = 0, la = 0, lb = 0, ereq, cfg_wr = 0, cmask = 1;
    logic cms = 0, cencs = 0, csfr = 0, bnd_s = 0, en = 1, eos = 0, brk = 0, mwr = 0, go = 0;
    logic [23:0] hw = '0, pend, ms;
    logic [4:0]  swi = 0, cidx = 0, src;
    logic [7:0]  evec, ccnt = 0, isr, vec, bwa;
    logic [2:0]  cbank = 0, bank;
    logic [19:0] maddr = 0;
    logic [15:0] mdat = 0, bwd;
    logic        acc, save, dis, ack, vld, mx, mb, bw;
    pic_pkg::pic_resp_type kind;
    int fails = 0, tests_run = 0;

    pic_top i_pic_top (.clk_i(clk), .rst_i(rst), .hw_req_i(hw), .sw_set_i(sw_set),
        .sw_idx_i(swi), .ext_request_line_a_i(la), .ext_request_line_b_i(lb),
        .ext_ctrl_req_i(ereq), .ext_vec_i(evec), .cfg_wr_i(cfg_wr), .cfg_idx_i(cidx),
        .cfg_mask_i(cmask), .cfg_ms_i(cms), .cfg_bank_switch_enable_i(cencs), .cfg_bank_i(cbank),
        .cfg_sfr_i(csfr), .cfg_cnt_i(ccnt), .instr_boundary_i(bnd_s), .irq_enabled_i(en),
        .eos_instr_i(eos), .brk_bank_i(brk), .brk_bank_num_i(3'h6), .mem_wr_i(mwr),
        .mem_addr_i(maddr), .mem_data_i(mdat), .internal_data_base_i(8'h12),
        .accept_o(acc), .resp_kind_o(kind), .irq_source_o(src), .bank_o(bank),
        .save_pc_psw_o(save), .disable_irq_o(dis), .in_service_o(isr), .pending_o(pend),
        .ms_sel_o(ms), .irq_ack_cycle_o(ack), .ext_vec_o(vec), .ext_vec_valid_o(vld),
        .macro_xfer_o(mx), .macro_ext_bus_o(mb), .bank_wr_o(bw), .bank_wr_addr_o(bwa),
        .bank_wr_data_o(bwd));

    pic_ext_ctrl_model i_pic_ext_ctrl_model (.clk_i(clk), .rst_i(rst), .go_i(go),
        .vec_i(8'h5a), .irq_ack_cycle_i(ack), .ext_ctrl_req_o(ereq), .ext_vec_o(evec));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic cfg(input logic [4:0] i, input logic m, c, input logic [2:0] b,
                       input logic f, input logic [7:0] n);
        @(posedge clk);
        {cfg_wr, cidx, cmask, cms, cencs, cbank, csfr, ccnt} <= {1'b1, i, 1'b0, m, c, b, f, n};
        @(posedge clk);
        cfg_wr <= 0;
        #1;
    endtask
    task automatic req(input logic [23:0] m);
        @(posedge clk);
        hw <= m;
        @(posedge clk);
        hw <= '0;
        #1;
    endtask
    // One instruction boundary, optionally ending an end-of-service or break instruction
    task automatic bnd(input logic e, k);
        @(posedge clk);
        {bnd_s, eos, brk} <= {1'b1, e, k};
        @(posedge clk);
        {bnd_s, eos, brk} <= 3'h0;
        #1;
    endtask
    task automatic took(input logic [2:0] k);
        chk("accept", acc, 1);
        chk("kind", kind, k);
    endtask
    task automatic eos2;
        bnd(1, 0);
        bnd(0, 0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #(25 * 4000);
        fails++;
        final_report;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        #1 chk("pend", pend, 0);
        chk("isr", isr, 0);
        cfg(6, 0, 0, 0, 0, 0);
        cfg(7, 0, 0, 0, 0, 0);
        cfg(3, 0, 0, 0, 0, 0);
        cfg(4, 0, 0, 0, 0, 0);
        req(24'h0000c0);
        repeat (3) @(posedge clk);
        #1 chk("accept", acc, 0);
        bnd(0, 0);
        took(pic_pkg::RESP_VECTOR);
        chk("src", src, 6);
        chk("isr", isr, 8'h04);
        bnd(0, 0);
        chk("accept", acc, 0);
        // Both pins rise together while group 2 is in service
        @(posedge clk);
        {la, lb} <= 2'h3;
        repeat (2) @(posedge clk);
        {la, lb} <= 2'h0;
        repeat (4) @(posedge clk);
        bnd(0, 0);
        chk("src", src, 3);
        chk("pend", pend, 24'h000090);
        bnd(1, 0);
        chk("isr", isr, 8'h04);
        bnd(0, 0);
        chk("accept", acc, 0);
        bnd(0, 0);
        chk("src", src, 4);
        bnd(1, 0);
        bnd(0, 0);
        bnd(1, 0);
        chk("isr", isr, 0);
        bnd(0, 0);
        chk("accept", acc, 0);
        bnd(0, 0);
        chk("src", src, 7);
        eos2;
        cfg(9, 0, 1, 5, 0, 0);
        cfg(10, 0, 1, 2, 0, 0);
        req(24'h000400);
        bnd(0, 0);
        took(pic_pkg::RESP_BANK);
        chk("bank", bank, 5);
        chk("save", save, 1);
        eos2;
        cfg(0, 0, 1, 3, 0, 0);
        req(24'h000001);
        bnd(0, 0);
        took(pic_pkg::RESP_VECTOR);
        eos2;
        cfg(12, 0, 0, 0, 0, 0);
        @(posedge clk);
        {sw_set, swi} <= {1'b1, 5'd12};
        @(posedge clk);
        sw_set <= 0;
        bnd(0, 0);
        chk("src", src, 12);
        eos2;
        cfg(15, 1, 0, 0, 0, 1);
        chk("ms", ms[15], 1);
        req(24'h008000);
        bnd(0, 0);
        took(pic_pkg::RESP_MACRO);
        chk("xfer", mx, 1);
        chk("xbus", mb, 1);
        chk("isr", isr, 0);
        @(posedge clk);
        #1 chk("ms", ms[15], 0);
        cfg(16, 1, 0, 0, 1, 2);
        req(24'h010000);
        bnd(0, 0);
        chk("xbus", mb, 0);
        chk("ms", ms[16], 1);
        req(24'h000040);
        bnd(0, 0);
        @(posedge clk);
        go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (4) @(posedge clk);
        bnd(0, 0);
        took(pic_pkg::RESP_EXT);
        chk("ack", ack, 1);
        chk("dis", dis, 1);
        @(posedge clk);
        en <= 0;
        #1 chk("ack", ack, 0);
        repeat (2) @(posedge clk);
        #1 chk("vld", vld, 1);
        chk("vec", vec, 8'h5a);
        req(24'h000008);
        bnd(0, 0);
        chk("accept", acc, 0);
        @(posedge clk);
        en <= 1;
        bnd(0, 0);
        chk("src", src, 3);
        eos2;
        eos2;
        bnd(0, 1);
        took(pic_pkg::RESP_BRK);
        chk("bank", bank, 6);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {mwr, maddr, mdat} <= {1'b1, (i == 0) ? 20'h12e34 : 20'h12d34, 16'hbeef};
            @(posedge clk);
            mwr <= 0;
            #1 chk("bw", bw, i == 0);
            if (i == 0) chk("bwa", {bwa, bwd}, 24'h34beef);
        end
        final_report;
    end
endmodule // tb
